// ===== core/io_map_defines.svh
// io_map_defines.svh: addresses, field positions and reset values of the
// peripheral register area.
// assumes: included by the register bank of the same block.
`ifndef IO_MAP_DEFINES_SVH
`define IO_MAP_DEFINES_SVH

// ---------------------------------------------------------------------
// data memory geometry
// ---------------------------------------------------------------------
`define IO_AW            8
`define IO_DW            4
`define IO_SPACE_WORDS   150
`define IO_DISPLAY_WORDS 32
`define IO_PERIPH_WORDS  22

// ---------------------------------------------------------------------
// register addresses
// ---------------------------------------------------------------------
`define ADDR_KEY_INPUT   8'hE0
`define ADDR_SW_LOW      8'hE2
`define ADDR_SW_HIGH     8'hE3
`define ADDR_TIMER       8'hE4
`define ADDR_SDATA_LOW   8'hE5
`define ADDR_SDATA_HIGH  8'hE6
`define ADDR_SCTRL       8'hE7
`define ADDR_KEY_MASK    8'hE8
`define ADDR_PS_MASK     8'hE9
`define ADDR_SW_MASK     8'hEA
`define ADDR_TM_MASK     8'hEB

// ---------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------
`define SCTRL_GO_BIT      3
`define SCTRL_EDGE_BIT    2
`define SCTRL_MODE_HI     1
`define SCTRL_MODE_LO     0
`define PS_PORT_BIT       2
`define PS_DIR_BIT        1
`define PS_SERIAL_BIT     0
`define SW_SLOW_BIT       1
`define SW_FAST_BIT       0
`define TM_TWO_HZ_BIT     2
`define TM_EIGHT_HZ_BIT   1
`define TM_THIRTYTWO_BIT  0

// ---------------------------------------------------------------------
// clock mode codes and reset values
// ---------------------------------------------------------------------
`define SCLK_SLAVE        2'h0
`define SCLK_MASTER_FULL  2'h2
`define SCLK_MASTER_HALF  2'h3
`define NIBBLE_ZERO       4'h0
`define BYTE_ZERO         8'h00
`define MODE_RST          2'h0
`define BIT_RST           1'b0
`define TM_MASK_W         3
`define SW_MASK_W         2

`endif

// ===== core/io_map_pkg.sv
// io_map_pkg: types shared by the register bank.
// assumes: nothing beyond a SystemVerilog compiler.
`default_nettype none

package io_map_pkg;

  // which register an address selects
  typedef enum logic [3:0] {
    sel_none,
    sel_key_input,
    sel_sw_low,
    sel_sw_high,
    sel_timer,
    sel_sdata_low,
    sel_sdata_high,
    sel_sctrl,
    sel_key_mask,
    sel_ps_mask,
    sel_sw_mask,
    sel_tm_mask
  } reg_sel_t;

endpackage : io_map_pkg

`default_nettype wire

// ===== core/bit_sync.sv
// bit_sync: two flip-flop synchroniser for a bundle of level inputs.
// assumes: each bit is an independent slow level, e.g. a key pin.
`default_nettype none

module bit_sync #(
  parameter int W = 4
) (
  input  wire logic         mclk_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] stage_one;

  // first stage feeds only the second stage
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      stage_one <= '0;
      sync_o    <= '0;
    end
    else
    begin
      stage_one <= async_i;
      sync_o    <= stage_one;
    end
  end

endmodule // bit_sync

`default_nettype wire

// ===== core/io_memory_map_regs.sv
// io_memory_map_regs: peripheral register area of the data memory of a
// 4-bit controller, addresses 0E0H to 0EBH.
// assumes: the cpu core drives address, strobes and write data on mclk_i;
// timer, stopwatch and serial engines sit on the same clock.
//
// Function
// - 150-word space; this bank decodes peripheral words
// - 0E5H holds serial data bits 0-3
// - 0E6H holds serial data bits 4-7
// - writing 1 to go bit starts transfer
// - reading go bit shows transfer running
// - edge select bit, read/write, resets zero
// - two-bit clock mode field, resets to slave
// - mask bits read/write, reset masked; key masks
// - port, serial and stopwatch mask positions
// - serial pin direction bit, resets to input
// - read-only clock timer stages, reset zero
// - clock timer masks; 2 Hz at D2, D3 zero
// - unused bits read zero, ignore writes
`default_nettype none
`include "io_map_defines.svh"

module io_memory_map_regs (
  input  wire logic                  mclk_i,
  input  wire logic                  nrst_i,
  // cpu data memory access
  input  wire logic [`IO_AW-1:0]     addr_i,
  input  wire logic                  rd_i,
  input  wire logic                  wr_i,
  input  wire logic [`IO_DW-1:0]     wdata_i,
  output logic      [`IO_DW-1:0]     rdata_o,
  output logic                       hit_o,
  // key pins and engine status
  input  wire logic [3:0]            key_input_bits_i,
  input  wire logic [3:0]            sw_hundredths_i,
  input  wire logic [3:0]            sw_tenths_i,
  input  wire logic [3:0]            clock_timer_stage_bits_i,
  input  wire logic                  serial_running_i,
  input  wire logic                  shift_load_i,
  input  wire logic [7:0]            shift_data_i,
  // interrupt factor flags from the sources
  input  wire logic                  key_factor_i,
  input  wire logic                  port_factor_i,
  input  wire logic                  serial_factor_i,
  input  wire logic [1:0]            sw_factor_i,
  input  wire logic [2:0]            timer_factor_i,
  // control towards the engines
  output logic [7:0]                 serial_shift_bits_o,
  output logic                       serial_go_o,
  output logic                       serial_edge_select_o,
  output logic                       serial_clk_mode_hi_o,
  output logic                       serial_clk_mode_lo_o,
  output logic                       serial_pin_direction_o,
  output logic [3:0]                 key_irq_enable_o,
  output logic                       port_irq_enable_o,
  output logic                       serial_irq_enable_o,
  output logic                       stopwatch_fast_irq_enable_o,
  output logic                       stopwatch_slow_irq_enable_o,
  output logic                       timer_two_hz_irq_enable_o,
  output logic                       timer_eight_hz_irq_enable_o,
  output logic                       timer_thirtytwo_hz_irq_enable_o,
  output logic                       irq_o
);

  // -------------------------------------------------------------------
  // address decode
  // -------------------------------------------------------------------
  // only the listed words exist; anything else selects nothing
  function automatic io_map_pkg::reg_sel_t decode(
    input logic [`IO_AW-1:0] a
  );
    io_map_pkg::reg_sel_t s;
    s = io_map_pkg::sel_none;
    if (a == `ADDR_KEY_INPUT)
      s = io_map_pkg::sel_key_input;
    else if (a == `ADDR_SW_LOW)
      s = io_map_pkg::sel_sw_low;
    else if (a == `ADDR_SW_HIGH)
      s = io_map_pkg::sel_sw_high;
    else if (a == `ADDR_TIMER)
      s = io_map_pkg::sel_timer;
    else if (a == `ADDR_SDATA_LOW)
      s = io_map_pkg::sel_sdata_low;
    else if (a == `ADDR_SDATA_HIGH)
      s = io_map_pkg::sel_sdata_high;
    else if (a == `ADDR_SCTRL)
      s = io_map_pkg::sel_sctrl;
    else if (a == `ADDR_KEY_MASK)
      s = io_map_pkg::sel_key_mask;
    else if (a == `ADDR_PS_MASK)
      s = io_map_pkg::sel_ps_mask;
    else if (a == `ADDR_SW_MASK)
      s = io_map_pkg::sel_sw_mask;
    else if (a == `ADDR_TM_MASK)
      s = io_map_pkg::sel_tm_mask;
    return s;
  endfunction

  io_map_pkg::reg_sel_t wr_sel;
  io_map_pkg::reg_sel_t rd_sel;

  assign wr_sel = wr_i ? decode(addr_i) : io_map_pkg::sel_none;
  assign rd_sel = decode(addr_i);

  // -------------------------------------------------------------------
  // key pin synchroniser
  // -------------------------------------------------------------------
  logic [3:0] key_sync;

  bit_sync #(
    .W (4)
  ) u_key_sync (
    .mclk_i  (mclk_i),
    .nrst_i  (nrst_i),
    .async_i (key_input_bits_i),
    .sync_o  (key_sync)
  );

  // -------------------------------------------------------------------
  // serial data register
  // -------------------------------------------------------------------
  // an engine load in the same cycle as a cpu write wins: the received
  // byte must not be lost behind a late software write
  logic [7:0] serial_shift_bits;

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      serial_shift_bits <= `BYTE_ZERO;
    end
    else if (shift_load_i)
    begin
      serial_shift_bits <= shift_data_i;
    end
    else if (wr_sel == io_map_pkg::sel_sdata_low)
    begin
      serial_shift_bits[3:0] <= wdata_i;
    end
    else if (wr_sel == io_map_pkg::sel_sdata_high)
    begin
      serial_shift_bits[7:4] <= wdata_i;
    end
  end

  assign serial_shift_bits_o = serial_shift_bits;

  // -------------------------------------------------------------------
  // serial control
  // -------------------------------------------------------------------
  logic       serial_edge_select;
  logic [1:0] serial_clk_mode;

  // go is a one-cycle trigger; writing 0 does nothing
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      serial_go_o <= `BIT_RST;
    end
    else
    begin
      serial_go_o <= (wr_sel == io_map_pkg::sel_sctrl)
                     && wdata_i[`SCTRL_GO_BIT];
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      serial_edge_select <= `BIT_RST;
      serial_clk_mode    <= `MODE_RST;
    end
    else if (wr_sel == io_map_pkg::sel_sctrl)
    begin
      serial_edge_select <= wdata_i[`SCTRL_EDGE_BIT];
      serial_clk_mode    <= wdata_i[`SCTRL_MODE_HI:`SCTRL_MODE_LO];
    end
  end

  assign serial_edge_select_o = serial_edge_select;
  assign serial_clk_mode_hi_o = serial_clk_mode[1];
  assign serial_clk_mode_lo_o = serial_clk_mode[0];

  // -------------------------------------------------------------------
  // interrupt masks and pin direction
  // -------------------------------------------------------------------
  logic [3:0]              key_mask;
  logic                    port_mask;
  logic                    serial_mask;
  logic                    pin_direction;
  logic [`SW_MASK_W-1:0]   sw_mask;
  logic [`TM_MASK_W-1:0]   tm_mask;

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      key_mask <= `NIBBLE_ZERO;
    end
    else if (wr_sel == io_map_pkg::sel_key_mask)
    begin
      key_mask <= wdata_i;
    end
  end

  // D3 of this word has no storage
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      port_mask     <= `BIT_RST;
      pin_direction <= `BIT_RST;
      serial_mask   <= `BIT_RST;
    end
    else if (wr_sel == io_map_pkg::sel_ps_mask)
    begin
      port_mask     <= wdata_i[`PS_PORT_BIT];
      pin_direction <= wdata_i[`PS_DIR_BIT];
      serial_mask   <= wdata_i[`PS_SERIAL_BIT];
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sw_mask <= '0;
    end
    else if (wr_sel == io_map_pkg::sel_sw_mask)
    begin
      sw_mask <= wdata_i[`SW_SLOW_BIT:`SW_FAST_BIT];
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      tm_mask <= '0;
    end
    else if (wr_sel == io_map_pkg::sel_tm_mask)
    begin
      tm_mask <= wdata_i[`TM_TWO_HZ_BIT:`TM_THIRTYTWO_BIT];
    end
  end

  assign key_irq_enable_o                = key_mask;
  assign port_irq_enable_o               = port_mask;
  assign serial_irq_enable_o             = serial_mask;
  assign serial_pin_direction_o          = pin_direction;
  assign stopwatch_fast_irq_enable_o     = sw_mask[`SW_FAST_BIT];
  assign stopwatch_slow_irq_enable_o     = sw_mask[`SW_SLOW_BIT];
  assign timer_two_hz_irq_enable_o       = tm_mask[`TM_TWO_HZ_BIT];
  assign timer_eight_hz_irq_enable_o     = tm_mask[`TM_EIGHT_HZ_BIT];
  assign timer_thirtytwo_hz_irq_enable_o = tm_mask[`TM_THIRTYTWO_BIT];

  // -------------------------------------------------------------------
  // interrupt request
  // -------------------------------------------------------------------
  // the key flag is shared by all four keys, so any enabled key lets
  // it through; per-key selection happens where the flag is made
  logic next_irq;

  always_comb
  begin
    next_irq = (key_factor_i    && (|key_mask))
            || (port_factor_i   && port_mask)
            || (serial_factor_i && serial_mask)
            || (|(sw_factor_i    & sw_mask))
            || (|(timer_factor_i & tm_mask));
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      irq_o <= `BIT_RST;
    end
    else
    begin
      irq_o <= next_irq;
    end
  end

  // -------------------------------------------------------------------
  // read path
  // -------------------------------------------------------------------
  logic [`IO_DW-1:0] next_rdata;
  logic              next_hit;

  always_comb
  begin
    next_rdata = `NIBBLE_ZERO;
    next_hit   = 1'b1;
    case (rd_sel)
      io_map_pkg::sel_key_input:
        next_rdata = key_sync;
      io_map_pkg::sel_sw_low:
        next_rdata = sw_hundredths_i;
      io_map_pkg::sel_sw_high:
        next_rdata = sw_tenths_i;
      io_map_pkg::sel_timer:
        next_rdata = clock_timer_stage_bits_i;
      io_map_pkg::sel_sdata_low:
        next_rdata = serial_shift_bits[3:0];
      io_map_pkg::sel_sdata_high:
        next_rdata = serial_shift_bits[7:4];
      io_map_pkg::sel_sctrl:
        next_rdata = {serial_running_i, serial_edge_select,
                      serial_clk_mode};
      io_map_pkg::sel_key_mask:
        next_rdata = key_mask;
      io_map_pkg::sel_ps_mask:
        next_rdata = {1'b0, port_mask, pin_direction,
                      serial_mask};
      io_map_pkg::sel_sw_mask:
        next_rdata = {2'h0, sw_mask};
      io_map_pkg::sel_tm_mask:
        next_rdata = {1'b0, tm_mask};
      default:
        next_hit = 1'b0;
    endcase
  end

  // read data is held until the next read so the core may sample late
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rdata_o <= `NIBBLE_ZERO;
      hit_o   <= 1'b0;
    end
    else if (rd_i)
    begin
      rdata_o <= next_rdata;
      hit_o   <= next_hit;
    end
  end

endmodule // io_memory_map_regs

`default_nettype wire

// ===== dv/io_map_checker.sv
// io_map_checker: port-level timing and value checks for the register bank.
// assumes: bound onto io_memory_map_regs; one clock, async low reset.
`default_nettype none

module io_map_checker (
  input wire logic       mclk_i,
  input wire logic       nrst_i,
  input wire logic [7:0] addr_i,
  input wire logic       rd_i,
  input wire logic       wr_i,
  input wire logic [3:0] wdata_i,
  input wire logic [3:0] rdata_o,
  input wire logic       hit_o,
  input wire logic [3:0] clock_timer_stage_bits_i,
  input wire logic       shift_load_i,
  input wire logic [7:0] shift_data_i,
  input wire logic [7:0] serial_shift_bits_o,
  input wire logic       serial_go_o,
  input wire logic       serial_edge_select_o,
  input wire logic       serial_clk_mode_hi_o,
  input wire logic       serial_clk_mode_lo_o,
  input wire logic       serial_pin_direction_o,
  input wire logic       key_factor_i,
  input wire logic       port_factor_i,
  input wire logic       serial_factor_i,
  input wire logic [1:0] sw_factor_i,
  input wire logic [2:0] timer_factor_i,
  input wire logic       serial_irq_enable_o,
  input wire logic       irq_o
);
  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);

  go_pulse_a: assert property (
    wr_i && addr_i == 8'hE7 && wdata_i[3] |=> serial_go_o)
    else $error("start pulse missing");
  go_quiet_a: assert property (
    !(wr_i && addr_i == 8'hE7 && wdata_i[3]) |=> !serial_go_o)
    else $error("start pulse without request");
  mode_set_a: assert property (
    wr_i && addr_i == 8'hE7 |=> {serial_edge_select_o,
    serial_clk_mode_hi_o, serial_clk_mode_lo_o} == $past(wdata_i[2:0]))
    else $error("clock mode not taken");
  dir_set_a: assert property (
    wr_i && addr_i == 8'hE9 |=> serial_pin_direction_o == $past(wdata_i[1]))
    else $error("pin direction not taken");
  mask_msb_a: assert property (
    rd_i && addr_i == 8'hE9 |=> rdata_o[3] == 1'h0 && hit_o)
    else $error("unused mask bit not zero");
  timer_read_a: assert property (
    rd_i && addr_i == 8'hE4 |=> rdata_o == $past(clock_timer_stage_bits_i))
    else $error("timer stages misread");
  gap_read_a: assert property (
    rd_i && (addr_i < 8'hE0 || addr_i == 8'hE1 || addr_i > 8'hEB)
    |=> rdata_o == 4'h0 && !hit_o)
    else $error("unlisted address read not zero");
  shift_load_a: assert property (
    shift_load_i |=> serial_shift_bits_o == $past(shift_data_i))
    else $error("engine load lost");
  irq_on_a: assert property (
    serial_factor_i && serial_irq_enable_o |=> irq_o)
    else $error("enabled request not raised");
  irq_off_a: assert property (
    !key_factor_i && !port_factor_i && !serial_factor_i &&
    sw_factor_i == 2'h0 && timer_factor_i == 3'h0 |=> !irq_o)
    else $error("request without factor");
endmodule // io_map_checker

bind io_memory_map_regs io_map_checker u_io_map_checker (
  .mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .rd_i(rd_i),
  .wr_i(wr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .hit_o(hit_o),
  .clock_timer_stage_bits_i(clock_timer_stage_bits_i),
  .shift_load_i(shift_load_i), .shift_data_i(shift_data_i),
  .serial_shift_bits_o(serial_shift_bits_o), .serial_go_o(serial_go_o),
  .serial_edge_select_o(serial_edge_select_o),
  .serial_clk_mode_hi_o(serial_clk_mode_hi_o),
  .serial_clk_mode_lo_o(serial_clk_mode_lo_o),
  .serial_pin_direction_o(serial_pin_direction_o),
  .key_factor_i(key_factor_i), .port_factor_i(port_factor_i),
  .serial_factor_i(serial_factor_i), .sw_factor_i(sw_factor_i),
  .timer_factor_i(timer_factor_i),
  .serial_irq_enable_o(serial_irq_enable_o), .irq_o(irq_o));

`default_nettype wire

// ===== dv/cpu_bus_model.sv
// cpu_bus_model: cpu core issuing data memory reads and writes.
// assumes: bank takes strobes on the rising edge, read data next cycle.
`default_nettype none

module cpu_bus_model (
  input  wire logic       mclk_i,
  input  wire logic [3:0] rdata_i,
  input  wire logic       hit_i,
  output logic      [7:0] addr_o,
  output logic            rd_o,
  output logic            wr_o,
  output logic      [3:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    addr_o = 8'h00;
    rd_o = 1'h0;
    wr_o = 1'h0;
    wdata_o = 4'h0;
  end

  // idle address and data flip so stale values never look valid
  task automatic write(input logic [7:0] a, input logic [3:0] d);
    @(negedge mclk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'h1;
    @(negedge mclk_i);
    wr_o = 1'h0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask

  task automatic read(input logic [7:0] a, output logic [3:0] d,
                      output logic h);
    @(negedge mclk_i);
    addr_o = a;
    rd_o = 1'h1;
    @(negedge mclk_i);
    rd_o = 1'h0;
    addr_o = ~a;
    d = rdata_i;
    h = hit_i;
  endtask
endmodule // cpu_bus_model

`default_nettype wire

// ===== dv/io_memory_map_regs_test.sv
// io_memory_map_regs_test: self-checking bench for the register bank.
// assumes: cpu_bus_model drives the bus; checker bound separately.
`default_nettype none

module io_memory_map_regs_test;
  timeunit 1ns;
  timeprecision 1ns;

  logic       mclk_i, nrst_i, rd_i, wr_i, hit_o, irq_o;
  logic [7:0] addr_i, shift_data_i, serial_shift_bits_o;
  logic [3:0] wdata_i, rdata_o, key_input_bits_i, key_irq_enable_o;
  logic [3:0] sw_hundredths_i, sw_tenths_i, clock_timer_stage_bits_i;
  logic       serial_running_i, shift_load_i, key_factor_i, port_factor_i;
  logic       serial_factor_i, serial_go_o, serial_edge_select_o;
  logic [1:0] sw_factor_i;
  logic [2:0] timer_factor_i;
  logic       serial_clk_mode_hi_o, serial_clk_mode_lo_o;
  logic       serial_pin_direction_o, port_irq_enable_o, serial_irq_enable_o;
  logic       stopwatch_fast_irq_enable_o, stopwatch_slow_irq_enable_o;
  logic       timer_two_hz_irq_enable_o, timer_eight_hz_irq_enable_o;
  logic       timer_thirtytwo_hz_irq_enable_o;
  int         num_errors = 0;
  int         n_tests = 0;

  io_memory_map_regs u_io_memory_map_regs (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .rd_i(rd_i),
    .wr_i(wr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .hit_o(hit_o),
    .key_input_bits_i(key_input_bits_i), .sw_hundredths_i(sw_hundredths_i),
    .sw_tenths_i(sw_tenths_i),
    .clock_timer_stage_bits_i(clock_timer_stage_bits_i),
    .serial_running_i(serial_running_i), .shift_load_i(shift_load_i),
    .shift_data_i(shift_data_i), .key_factor_i(key_factor_i),
    .port_factor_i(port_factor_i), .serial_factor_i(serial_factor_i),
    .sw_factor_i(sw_factor_i), .timer_factor_i(timer_factor_i),
    .serial_shift_bits_o(serial_shift_bits_o), .serial_go_o(serial_go_o),
    .serial_edge_select_o(serial_edge_select_o),
    .serial_clk_mode_hi_o(serial_clk_mode_hi_o),
    .serial_clk_mode_lo_o(serial_clk_mode_lo_o),
    .serial_pin_direction_o(serial_pin_direction_o),
    .key_irq_enable_o(key_irq_enable_o),
    .port_irq_enable_o(port_irq_enable_o),
    .serial_irq_enable_o(serial_irq_enable_o),
    .stopwatch_fast_irq_enable_o(stopwatch_fast_irq_enable_o),
    .stopwatch_slow_irq_enable_o(stopwatch_slow_irq_enable_o),
    .timer_two_hz_irq_enable_o(timer_two_hz_irq_enable_o),
    .timer_eight_hz_irq_enable_o(timer_eight_hz_irq_enable_o),
    .timer_thirtytwo_hz_irq_enable_o(timer_thirtytwo_hz_irq_enable_o),
    .irq_o(irq_o));
  cpu_bus_model u_cpu_bus_model (.mclk_i(mclk_i), .rdata_i(rdata_o),
    .hit_i(hit_o), .addr_o(addr_i), .rd_o(rd_i), .wr_o(wr_i),
    .wdata_o(wdata_i));

  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick();
    @(negedge mclk_i);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [3:0] e,
                      input logic h);
    logic [3:0] d;
    logic       hv;
    u_cpu_bus_model.read(a, d, hv);
    chk("rdata", {4'h0, d}, {4'h0, e});
    chk("hit", {7'h00, hv}, {7'h00, h});
  endtask

  function automatic logic [7:0] enables();
    return {1'h0, port_irq_enable_o, serial_irq_enable_o,
      stopwatch_fast_irq_enable_o, stopwatch_slow_irq_enable_o,
      timer_two_hz_irq_enable_o, timer_eight_hz_irq_enable_o,
      timer_thirtytwo_hz_irq_enable_o};
  endfunction

  task automatic finish_test();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // -------------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------------
  task automatic t_reset();
    chk("ctrl", {4'h0, serial_go_o, serial_edge_select_o,
      serial_clk_mode_hi_o, serial_clk_mode_lo_o}, 8'h00);
    chk("dir", {7'h00, serial_pin_direction_o}, 8'h00);
    for (int a = 8'hE7; a <= 8'hEB; a++)
      rchk(a[7:0], 4'h0, 1'h1);
    rchk(8'hE4, 4'h0, 1'h1);
  endtask

  task automatic t_masks();
    logic [3:0] e[4] = '{4'hF, 4'h7, 4'h3, 4'h7};
    for (int i = 0; i < 4; i++)
      u_cpu_bus_model.write(8'hE8 + i[7:0], 4'hF);
    chk("key_en", {4'h0, key_irq_enable_o}, 8'h0F);
    chk("enables", enables(), 8'h7F);
    chk("dir", {7'h00, serial_pin_direction_o}, 8'h01);
    for (int i = 0; i < 4; i++)
      rchk(8'hE8 + i[7:0], e[i], 1'h1);
    for (int i = 0; i < 4; i++)
      u_cpu_bus_model.write(8'hE8 + i[7:0], 4'h0);
    chk("enables", enables(), 8'h00);
  endtask

  task automatic t_serial();
    u_cpu_bus_model.write(8'hE5, 4'hA);
    u_cpu_bus_model.write(8'hE6, 4'h5);
    chk("shift", serial_shift_bits_o, 8'h5A);
    rchk(8'hE6, 4'h5, 1'h1);
    shift_load_i = 1'h1;
    shift_data_i = 8'hC3;
    tick();
    shift_load_i = 1'h0;
    rchk(8'hE5, 4'h3, 1'h1);
  endtask

  task automatic t_ctrl();
    logic [1:0] m[3] = '{2'h0, 2'h2, 2'h3};
    for (int i = 0; i < 3; i++)
    begin
      u_cpu_bus_model.write(8'hE7, {1'h1, i[0], m[i]});
      chk("go", {7'h00, serial_go_o}, 8'h01);
      chk("mode", {5'h00, serial_edge_select_o, serial_clk_mode_hi_o,
        serial_clk_mode_lo_o}, {5'h00, i[0], m[i]});
      tick();
      chk("go", {7'h00, serial_go_o}, 8'h00);
    end
    u_cpu_bus_model.write(8'hE7, 4'h7);
    chk("go", {7'h00, serial_go_o}, 8'h00);
    serial_running_i = 1'h1;
    rchk(8'hE7, 4'hF, 1'h1);
    serial_running_i = 1'h0;
    rchk(8'hE7, 4'h7, 1'h1);
  endtask

  task automatic t_ro();
    clock_timer_stage_bits_i = 4'h6;
    for (int a = 8'hE0; a <= 8'hE4; a++)
      u_cpu_bus_model.write(a[7:0], 4'hF);
    rchk(8'hE0, 4'h9, 1'h1);
    rchk(8'hE2, 4'h3, 1'h1);
    rchk(8'hE3, 4'h8, 1'h1);
    rchk(8'hE4, 4'h6, 1'h1);
  endtask

  task automatic t_gap();
    logic [7:0] g[4] = '{8'h00, 8'hE1, 8'hEC, 8'hFF};
    for (int i = 0; i < 4; i++)
    begin
      u_cpu_bus_model.write(g[i], 4'hF);
      rchk(g[i], 4'h0, 1'h0);
    end
    rchk(8'hE8, 4'h0, 1'h1);
  endtask

  // all factors held high: only the one enabled source may pass
  task automatic t_irq();
    logic [7:0] a[7] = '{8'hE8, 8'hE9, 8'hE9, 8'hE9, 8'hEA, 8'hEA, 8'hEB};
    logic [3:0] d[7] = '{4'h2, 4'h4, 4'h1, 4'h2, 4'h1, 4'h2, 4'h4};
    {key_factor_i, port_factor_i, serial_factor_i} = 3'h7;
    sw_factor_i = 2'h3;
    timer_factor_i = 3'h7;
    for (int i = 0; i < 7; i++)
    begin
      u_cpu_bus_model.write(a[i], d[i]);
      tick();
      chk("irq", {7'h00, irq_o}, {7'h00, i != 3});
      u_cpu_bus_model.write(a[i], 4'h0);
      tick();
      chk("irq", {7'h00, irq_o}, 8'h00);
    end
  endtask

  // -------------------------------------------------------------------
  // run
  // -------------------------------------------------------------------
  initial
  begin
    mclk_i = 1'h0;
    forever #20 mclk_i = ~mclk_i;
  end

  initial
  begin
    repeat (5000) @(posedge mclk_i);
    num_errors++;
    finish_test();
  end

  initial
  begin
    nrst_i = 1'h0;
    key_input_bits_i = 4'h9;
    sw_hundredths_i = 4'h3;
    sw_tenths_i = 4'h8;
    clock_timer_stage_bits_i = 4'h0;
    {serial_running_i, shift_load_i, shift_data_i} = 10'h000;
    {key_factor_i, port_factor_i, serial_factor_i} = 3'h0;
    sw_factor_i = 2'h0;
    timer_factor_i = 3'h0;
    repeat (6) @(negedge mclk_i);
    nrst_i = 1'h1;
    t_reset();
    t_masks();
    t_serial();
    t_ctrl();
    t_ro();
    t_gap();
    t_irq();
    finish_test();
  end
endmodule // io_memory_map_regs_test

`default_nettype wire
